/* common/lcd_col_pkg.sv */
// shared constants, level codes and slot mapping for the 80-column driver
// assumes all users import the whole package
package lcd_col_pkg;

  localparam int COLUMN_COUNT = 80;
  localparam int NIBBLE_WIDTH = 4;
  localparam int NIBBLES_PER_ROW = COLUMN_COUNT / NIBBLE_WIDTH;
  localparam int LEVEL_WIDTH = 2;
  localparam int COUNT_WIDTH = 5;
  localparam int SLOT_WIDTH = 7;

  // four drive levels; one and two select, three and four do not
  typedef enum logic [1:0] {
    LEVEL_ONE = 2'h0,
    LEVEL_TWO = 2'h1,
    LEVEL_THREE = 2'h2,
    LEVEL_FOUR = 2'h3
  } drive_level_type;

  typedef enum logic {
    FILL_ARMED = 1'b0,
    FILL_DONE = 1'b1
  } fill_state_type;

  localparam logic DIR_FROM_FIRST = 1'h0;
  localparam logic POLARITY_PLUS = 1'h0;
  localparam logic CARRY_IDLE_N = 1'h1;
  localparam logic CLOCK_RESET_LEVEL = 1'h0;
  localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 5'h00;
  localparam logic [COUNT_WIDTH-1:0] COUNT_LAST = 5'(NIBBLES_PER_ROW - 1);
  localparam logic [SLOT_WIDTH-1:0] SLOT_LAST = 7'(COLUMN_COUNT - 1);
  localparam logic [1:0] BIT_TOP = 2'h3;

  // column index (0 based) that nibble bit bitPos of nibble nibbleCount lands on
  function automatic logic [SLOT_WIDTH-1:0] slotIndex(input logic [COUNT_WIDTH-1:0] nibbleCount,
                                                      input logic [1:0] bitPos,
                                                      input logic direction);
    logic [SLOT_WIDTH-1:0] fromFirst;
    fromFirst = {nibbleCount, 2'h0} + 7'(BIT_TOP - bitPos);
    slotIndex = (direction == DIR_FROM_FIRST) ? fromFirst : SLOT_LAST - fromFirst;
  endfunction

  // level chosen by a pixel bit and the ac polarity
  function automatic drive_level_type levelFor(input logic pixel, input logic polarity);
    if (polarity == POLARITY_PLUS) begin
      levelFor = pixel ? LEVEL_ONE : LEVEL_THREE;
    end else begin
      levelFor = pixel ? LEVEL_TWO : LEVEL_FOUR;
    end
  endfunction

endpackage

/* common/nibble_load_if.sv */
// link between the driver top and its nibble loader
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface nibble_load_if;
  import lcd_col_pkg::*;

  logic shiftStrobe;
  logic [NIBBLE_WIDTH-1:0] nibble;
  logic direction;
  logic rearm;
  logic [COLUMN_COUNT-1:0] row;
  logic full;
  logic [COUNT_WIDTH-1:0] count;

  modport loader (input shiftStrobe, nibble, direction, rearm, output row, full, count);
  modport driver (output shiftStrobe, nibble, direction, rearm, input row, full, count);
endinterface
`default_nettype wire

/* test/lcd_ctrl_model.sv */
// display controller model: shift clock, pixel nibbles, line latch clock, ac polarity
// assumes one bench process calls its tasks, after reset, on the shared clk
`timescale 1ns/1ps
`default_nettype none
module lcd_ctrl_model
  import lcd_col_pkg::*;
(
  // clock
  input wire logic clk,
  // controller outputs
  output var logic lineLatchClock,
  output var logic nibbleShiftClock,
  output var logic [NIBBLE_WIDTH-1:0] pixelNibble,
  output var logic acPolarity
);
  initial begin
    lineLatchClock = 1'h0;
    nibbleShiftClock = 1'h0;
    pixelNibble = 4'h0;
    acPolarity = POLARITY_PLUS;
  end

  // data held across the falling shift edge, then shown inverted as released
  task automatic sendNibble(input logic [NIBBLE_WIDTH-1:0] n);
    @(posedge clk);
    nibbleShiftClock <= 1'h1;
    pixelNibble <= n;
    @(posedge clk);
    nibbleShiftClock <= 1'h0;
    @(posedge clk);
    pixelNibble <= ~n;
  endtask

  task automatic latchRow();
    @(posedge clk);
    lineLatchClock <= 1'h1;
    @(posedge clk);
    lineLatchClock <= 1'h0;
  endtask

  task automatic setPolarity(input logic p);
    @(posedge clk);
    acPolarity <= p;
  endtask
endmodule
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the 80-column driver
// assumes the controller model drives all shift, latch and polarity inputs
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lcd_col_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic loadDirectionSelect = 1'h0;
  logic chainEnable_n = 1'h0;
  wire logic lineLatchClock;
  wire logic nibbleShiftClock;
  wire logic [NIBBLE_WIDTH-1:0] pixelNibble;
  wire logic acPolarity;
  logic chainCarry_n;
  logic [COLUMN_COUNT*LEVEL_WIDTH-1:0] columnOutputs;
  logic [COLUMN_COUNT-1:0] expRow = '0;
  logic [COLUMN_COUNT-1:0] oldRow;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;

  lcd_ctrl_model i_lcd_ctrl_model (.clk(clk), .lineLatchClock(lineLatchClock),
    .nibbleShiftClock(nibbleShiftClock), .pixelNibble(pixelNibble), .acPolarity(acPolarity));
  lcd_column_driver_80 i_lcd_column_driver_80 (.clk(clk), .rst(rst),
    .lineLatchClock(lineLatchClock), .nibbleShiftClock(nibbleShiftClock),
    .pixelNibble(pixelNibble), .loadDirectionSelect(loadDirectionSelect),
    .acPolarity(acPolarity), .chainEnable_n(chainEnable_n), .chainCarry_n(chainCarry_n),
    .columnOutputs(columnOutputs));

  always #25 clk = ~clk;

  task automatic close_out();
    if (miscompares == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic check(input logic ok, input string what);
    n_compared++;
    if (!ok) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask

  function automatic drive_level_type lvl(input logic p, input logic pol);
    if (pol) return p ? LEVEL_TWO : LEVEL_FOUR;
    return p ? LEVEL_ONE : LEVEL_THREE;
  endfunction

  task automatic checkCols(input logic [COLUMN_COUNT-1:0] row, input logic pol);
    for (int i = 0; i < COLUMN_COUNT; i++) begin
      check(columnOutputs[2*i+:2] === lvl(row[i], pol), "column level");
    end
  endtask

  task automatic loadRow(input logic dir, input logic [3:0] key);
    logic [3:0] n;
    int slot;
    @(posedge clk);
    loadDirectionSelect <= dir;
    for (int k = 0; k < 20; k++) begin
      n = 4'(k) ^ key;
      i_lcd_ctrl_model.sendNibble(n);
      for (int b = 0; b < 4; b++) begin
        slot = 4 * k + 3 - b;
        expRow[dir ? 79 - slot : slot] = n[b];
      end
    end
    repeat (3) @(posedge clk);
    #1;
    check(chainCarry_n === 1'h0, "carry not low after full row");
  endtask

  task automatic latchAndWait();
    i_lcd_ctrl_model.latchRow();
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic fillForward();
    loadRow(1'h0, 4'h5);
    i_lcd_ctrl_model.sendNibble(4'hF);
    latchAndWait();
    checkCols(expRow, 1'h0);
    check(chainCarry_n === 1'h1, "carry not rearmed");
  endtask

  task automatic polaritySwap();
    i_lcd_ctrl_model.setPolarity(1'h1);
    repeat (2) @(posedge clk);
    #1;
    checkCols(expRow, 1'h1);
    i_lcd_ctrl_model.setPolarity(1'h0);
    repeat (2) @(posedge clk);
    #1;
    checkCols(expRow, 1'h0);
  endtask

  task automatic fillMirror();
    oldRow = expRow;
    loadRow(1'h1, 4'hC);
    checkCols(oldRow, 1'h0);
    latchAndWait();
    checkCols(expRow, 1'h0);
  endtask

  task automatic disabledLoad();
    @(posedge clk);
    chainEnable_n <= 1'h1;
    for (int k = 0; k < 20; k++) i_lcd_ctrl_model.sendNibble(4'(k) ^ 4'h9);
    repeat (3) @(posedge clk);
    #1;
    check(chainCarry_n === 1'h1, "carry fell while disabled");
    @(posedge clk);
    chainEnable_n <= 1'h0;
    latchAndWait();
    checkCols(expRow, 1'h0);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    fillForward();
    polaritySwap();
    fillMirror();
    disabledLoad();
    close_out();
  end
endmodule
`default_nettype wire

/* verilog/lcd_column_driver_80.sv */
// 80-column dot-matrix lcd driver: nibble loading, line latch, level select
// assumes every input is synchronous to clk, which runs far above the shift rate
//
// Contract
// - There are 80 column outputs, each at one of four levels set by its latched pixel and polarity.
// - Pixels arrive four at a time and a one selects while a zero does not select.
// - A nibble is captured when the shift clock falls.
// - When the line latch clock falls the collected row is copied into the output latch.
// - Column levels change with the line latch fall, never at shift clock edges.
// - The controller drives polarity and the device swaps level pairs with it.
// - With direction zero bit three fills column 1,5..77 and bit zero column 4,8..80.
// - Shift clock and nibble are ignored while the enable input is high.
// - Drivers chain through enable and carry, handing on once their columns are full.
// - Loading is four bits wide with direction select choosing the end filled first.
`timescale 1ns/1ps
`default_nettype none
module lcd_column_driver_80
  import lcd_col_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // controller clocks and data
  input wire logic lineLatchClock,
  input wire logic nibbleShiftClock,
  input wire logic [NIBBLE_WIDTH-1:0] pixelNibble,
  input wire logic loadDirectionSelect,
  input wire logic acPolarity,
  // cascade
  input wire logic chainEnable_n,
  output logic chainCarry_n,
  // column drive level codes, two bits per column
  output logic [COLUMN_COUNT*LEVEL_WIDTH-1:0] columnOutputs
);

  nibble_load_if load ();

  nibble_loader loader (
    .clk(clk),
    .rst(rst),
    .load(load)
  );

  logic prevShift;
  logic prevLatch;
  logic [COLUMN_COUNT-1:0] latched;
  logic [COLUMN_COUNT-1:0] next_latched;
  logic [COLUMN_COUNT*LEVEL_WIDTH-1:0] next_columnOutputs;
  wire logic shiftFall;
  wire logic latchFall;
  wire logic enabled;

  assign enabled = ~chainEnable_n;
  assign shiftFall = prevShift & ~nibbleShiftClock;
  assign latchFall = prevLatch & ~lineLatchClock;

  // a disabled device sees neither shift edges nor data
  assign load.shiftStrobe = shiftFall & enabled;
  assign load.nibble = enabled ? pixelNibble : '0;
  assign load.direction = loadDirectionSelect;
  assign load.rearm = latchFall;

  assign next_latched = latchFall ? load.row : latched;

  // levels follow the latch, so shift activity never reaches the columns
  always_comb begin
    next_columnOutputs = '0;
    for (int i = 0; i < COLUMN_COUNT; i++) begin
      next_columnOutputs[i*LEVEL_WIDTH +: LEVEL_WIDTH] =
        levelFor(next_latched[i], acPolarity);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prevShift <= CLOCK_RESET_LEVEL;
      prevLatch <= CLOCK_RESET_LEVEL;
      latched <= '0;
      columnOutputs <= '0;
      chainCarry_n <= CARRY_IDLE_N;
    end else begin
      prevShift <= nibbleShiftClock;
      prevLatch <= lineLatchClock;
      latched <= next_latched;
      columnOutputs <= next_columnOutputs;
      chainCarry_n <= ~load.full;
    end
  end

  chk_carry_after_fill: assert property (@(posedge clk) disable iff (rst)
    (load.shiftStrobe && load.count == COUNT_LAST && !load.full && !latchFall)
    |=> ##1 !chainCarry_n)
    else $error("carry not low after last nibble");

  chk_carry_idle: assert property (@(posedge clk) disable iff (rst)
    latchFall |=> ##1 chainCarry_n)
    else $error("carry stayed low after re-arm");

  chk_latch_copy: assert property (@(posedge clk) disable iff (rst)
    latchFall |=> latched == $past(load.row))
    else $error("row not copied on latch fall");

  chk_levels_steady: assert property (@(posedge clk) disable iff (rst)
    (!latchFall && $stable(acPolarity) && shiftFall) |=> $stable(columnOutputs))
    else $error("columns moved on a shift edge");

  // table written out here so a slip in the shared level function still shows
  chk_level_map: assert property (@(posedge clk) disable iff (rst)
    !rst |=> columnOutputs[LEVEL_WIDTH-1:0] == ($past(acPolarity) ?
      ($past(next_latched[0]) ? LEVEL_TWO : LEVEL_FOUR) :
      ($past(next_latched[0]) ? LEVEL_ONE : LEVEL_THREE)))
    else $error("column one level wrong");

  chk_polarity_swap: assert property (@(posedge clk) disable iff (rst)
    (!latchFall && acPolarity != POLARITY_PLUS && latched[1])
    |=> columnOutputs[2*LEVEL_WIDTH-1:LEVEL_WIDTH] == LEVEL_TWO)
    else $error("polarity did not swap level pair");

  chk_disabled_ignore: assert property (@(posedge clk) disable iff (rst)
    (chainEnable_n && !latchFall) |=> $stable(load.row))
    else $error("disabled device took a nibble");

  // reset leaves carry idle and every column at the level-one code
  chk_reset_carry: assert property (@(posedge clk)
    rst |=> chainCarry_n == CARRY_IDLE_N)
    else $error("carry not idle after reset");

  chk_reset_levels: assert property (@(posedge clk)
    rst |=> columnOutputs == '0)
    else $error("columns not at reset level");

  // a disabled device passes neither strobes nor data to the loader
  chk_strobe_gated: assert property (@(posedge clk) disable iff (rst)
    chainEnable_n |-> !load.shiftStrobe)
    else $error("shift strobe passed while disabled");

  chk_nibble_gated: assert property (@(posedge clk) disable iff (rst)
    chainEnable_n |-> load.nibble == '0)
    else $error("nibble passed while disabled");

  // edge history is reset low, so the sample right after reset is left out
  chk_strobe_on_fall: assert property (@(posedge clk) disable iff (rst)
    (!chainEnable_n && !nibbleShiftClock && $past(nibbleShiftClock) && !$past(rst))
    |-> load.shiftStrobe)
    else $error("shift fall not taken");

  chk_no_strobe_high: assert property (@(posedge clk) disable iff (rst)
    nibbleShiftClock |-> !load.shiftStrobe)
    else $error("strobe while shift clock high");

  chk_latch_on_fall: assert property (@(posedge clk) disable iff (rst)
    (!lineLatchClock && $past(lineLatchClock) && !$past(rst)) |-> load.rearm)
    else $error("latch fall not seen");

  chk_no_latch_high: assert property (@(posedge clk) disable iff (rst)
    lineLatchClock |-> !load.rearm)
    else $error("latch taken while latch clock high");

  // between latch falls the output latch holds, and the levels hold while polarity is steady
  chk_latch_hold: assert property (@(posedge clk) disable iff (rst)
    !latchFall |=> $stable(latched))
    else $error("output latch moved without latch fall");

  chk_levels_hold: assert property (@(posedge clk) disable iff (rst)
    (!latchFall && $stable(acPolarity) && !$past(rst))
    |=> $stable(columnOutputs))
    else $error("columns moved without latch fall or polarity change");

  chk_latch_drops_nibble: assert property (@(posedge clk) disable iff (rst)
    latchFall |=> $stable(load.row))
    else $error("nibble taken on a latch fall");

  // carry follows the loader's full flag one edge later
  chk_carry_armed: assert property (@(posedge clk) disable iff (rst)
    !load.full |=> chainCarry_n)
    else $error("carry low while loading is armed");

  chk_carry_full: assert property (@(posedge clk) disable iff (rst)
    load.full |=> !chainCarry_n)
    else $error("carry high while row is full");

  // level table at the first and last column, against the level codes
  chk_level_one: assert property (@(posedge clk) disable iff (rst)
    (!rst && !latchFall && acPolarity == POLARITY_PLUS && latched[0])
    |=> columnOutputs[LEVEL_WIDTH-1:0] == LEVEL_ONE)
    else $error("selected column not at level one");

  chk_level_three: assert property (@(posedge clk) disable iff (rst)
    (!rst && !latchFall && acPolarity == POLARITY_PLUS && !latched[0])
    |=> columnOutputs[LEVEL_WIDTH-1:0] == LEVEL_THREE)
    else $error("unselected column not at level three");

  chk_level_four: assert property (@(posedge clk) disable iff (rst)
    (!rst && !latchFall && acPolarity != POLARITY_PLUS && !latched[0])
    |=> columnOutputs[LEVEL_WIDTH-1:0] == LEVEL_FOUR)
    else $error("unselected column not at level four");

  chk_last_column: assert property (@(posedge clk) disable iff (rst)
    (!rst && !latchFall && acPolarity == POLARITY_PLUS && latched[COLUMN_COUNT-1])
    |=> columnOutputs[COLUMN_COUNT*LEVEL_WIDTH-1 -: LEVEL_WIDTH] == LEVEL_ONE)
    else $error("last column not at level one");

  chk_last_three: assert property (@(posedge clk) disable iff (rst)
    (!rst && !latchFall && acPolarity == POLARITY_PLUS && !latched[COLUMN_COUNT-1])
    |=> columnOutputs[COLUMN_COUNT*LEVEL_WIDTH-1 -: LEVEL_WIDTH] == LEVEL_THREE)
    else $error("last column not at level three");

  chk_last_four: assert property (@(posedge clk) disable iff (rst)
    (!rst && !latchFall && acPolarity != POLARITY_PLUS && !latched[COLUMN_COUNT-1])
    |=> columnOutputs[COLUMN_COUNT*LEVEL_WIDTH-1 -: LEVEL_WIDTH] == LEVEL_FOUR)
    else $error("last column not at level four");

  chk_select_pair: assert property (@(posedge clk) disable iff (rst)
    (!rst && !latchFall && latched[0])
    |=> columnOutputs[LEVEL_WIDTH-1:0] inside {LEVEL_ONE, LEVEL_TWO})
    else $error("pixel one not at a selection level");

  chk_nonselect_pair: assert property (@(posedge clk) disable iff (rst)
    (!rst && !latchFall && !latched[0])
    |=> columnOutputs[LEVEL_WIDTH-1:0] inside {LEVEL_THREE, LEVEL_FOUR})
    else $error("pixel zero not at a non-selection level");

endmodule
`default_nettype wire

/* verilog/nibble_loader.sv */
// collects pixel nibbles into the 80-bit row in either fill direction
// assumes strobe is already gated by the chain enable
`timescale 1ns/1ps
`default_nettype none
module nibble_loader
  import lcd_col_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link to the driver top
  nibble_load_if.loader load
);

  fill_state_type fillState;
  fill_state_type next_fillState;
  logic [COUNT_WIDTH-1:0] count;
  logic [COLUMN_COUNT-1:0] row;
  wire logic takeNibble;
  wire logic lastNibble;

  assign takeNibble = load.shiftStrobe & (fillState == FILL_ARMED) & ~load.rearm;
  assign lastNibble = (count == COUNT_LAST);

  always_comb begin
    case (fillState)
      FILL_ARMED: next_fillState = (takeNibble && lastNibble) ? FILL_DONE : FILL_ARMED;
      FILL_DONE: next_fillState = FILL_DONE;
      default: next_fillState = FILL_ARMED;
    endcase
    if (load.rearm) begin
      next_fillState = FILL_ARMED;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fillState <= FILL_ARMED;
      count <= COUNT_RESET;
      row <= '0;
    end else begin
      fillState <= next_fillState;
      if (load.rearm) begin
        count <= COUNT_RESET;
      end else if (takeNibble && !lastNibble) begin
        count <= count + 5'h01;
      end
      if (takeNibble) begin
        // each nibble bit lands one column apart from its neighbours' slots
        for (int b = 0; b < NIBBLE_WIDTH; b++) begin
          row[slotIndex(count, 2'(b), load.direction)] <= load.nibble[b];
        end
      end
    end
  end

  assign load.row = row;
  assign load.full = (fillState == FILL_DONE);
  assign load.count = count;

  chk_first_slot: assert property (@(posedge clk) disable iff (rst)
    (takeNibble && count == COUNT_RESET && load.direction == DIR_FROM_FIRST)
    |=> (row[0] == $past(load.nibble[3]) && row[3] == $past(load.nibble[0])))
    else $error("first nibble not placed at columns one to four");

  chk_reverse_slot: assert property (@(posedge clk) disable iff (rst)
    (takeNibble && count == COUNT_RESET && load.direction != DIR_FROM_FIRST)
    |=> row[COLUMN_COUNT-1] == $past(load.nibble[3]))
    else $error("reverse fill did not start at the far end");

  chk_full_ignores: assert property (@(posedge clk) disable iff (rst)
    (load.full && !load.rearm) |=> $stable(row))
    else $error("row changed while full");

  chk_rearm_clears: assert property (@(posedge clk) disable iff (rst)
    load.rearm |=> (!load.full && count == COUNT_RESET))
    else $error("latch edge did not re-arm loading");

endmodule
`default_nettype wire
